// ### hw/crf_resync_top.sv
// top: AHB-Lite register slave, bit resynchronisation and acceptance filter registers
`include "crf_defs.svh"
`default_nettype none
module crf_resync_top
    import crf_pkg::*;
#(
    parameter int NUM_FILT = 3
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic TQ_TICK,
    input wire logic [2:0] PROP_LEN,
    input wire logic [2:0] SEG1_LEN,
    input wire logic [2:0] SEG2_LEN,
    input wire logic RX_EDGE,
    input wire logic HARD_SYNC,
    input wire logic [28:0] RX_ID,
    input wire logic RX_IDE,
    input wire logic RX_ID_VALID,
    output logic [5:0] PRESCALE,
    output logic [1:0] BIT_PHASE,
    output logic SAMPLE_POINT,
    output logic BIT_START,
    output logic [NUM_FILT-1:0] FILTER_HIT
);
    // further filters would continue at the same stride
    if (NUM_FILT < 1 || NUM_FILT > 6) begin : g_chk // R11
        $error("NUM_FILT must be 1 to 6");
    end

    localparam logic [11:0] FILT_STRIDE = `CRF_F1_SID_IDX - `CRF_F0_SID_IDX; // R10
    localparam logic [11:0] EIDH_OFS = `CRF_F0_EIDH_IDX - `CRF_F0_SID_IDX; // R10
    localparam logic [11:0] EIDL_OFS = `CRF_F0_EIDL_IDX - `CRF_F0_SID_IDX; // R10

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_n);

    // bus slave: one wait state on every transfer, so a write always lands
    // before the next address phase can be sampled and no forwarding is needed
    logic accept;
    logic pend;
    logic pend_write;
    logic pend_ok;
    logic [11:0] pend_idx;
    logic wr_strobe;
    logic rd_strobe;
    logic [15:0] rd_val;

    assign accept = HSEL && HTRANS[1] && HREADY;
    assign wr_strobe = pend && pend_write && pend_ok;
    assign rd_strobe = pend && !pend_write;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            pend <= 1'b0;
            pend_write <= 1'b0;
            pend_ok <= 1'b0;
            pend_idx <= 12'h000;
            HREADYOUT <= 1'b1;
        end else if (accept) begin
            pend <= 1'b1;
            pend_write <= HWRITE;
            pend_ok <= (HADDR[31:14] == 18'h00000) && (HADDR[1:0] == 2'h0)
                && (HSIZE == `CRF_HSIZE_WORD);
            pend_idx <= HADDR[13:2];
            HREADYOUT <= 1'b0;
        end else if (pend) begin
            pend <= 1'b0;
            HREADYOUT <= 1'b1;
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            HRDATA <= 32'h00000000;
        end else if (rd_strobe) begin
            HRDATA <= {16'h0000, rd_val};
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
        end
    end

    // configuration register: jump width and the prescaler handed on
    logic [7:0] cfg1;
    logic [1:0] jump_width_field;
    crf_tq_t sjw_tq;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            cfg1 <= `CRF_CFG1_RST;
        end else if (wr_strobe && pend_idx == `CRF_CFG1_IDX) begin
            cfg1 <= HWDATA[7:0];
        end
    end

    assign jump_width_field = cfg1[`CRF_SJW_HI:`CRF_SJW_LO]; // R3
    assign sjw_tq = {2'b00, jump_width_field} + 4'h1; // R12 R5
    assign PRESCALE = cfg1[`CRF_BRP_HI:0];

    // bit timing engine, counted in time quanta
    crf_seg_t seg;
    crf_seg_t next_seg;
    crf_tq_t tq_cnt;
    crf_tq_t next_cnt;
    crf_tq_t ph1_lim;
    crf_tq_t next_ph1;
    crf_tq_t ph2_lim;
    crf_tq_t next_ph2;
    logic resynced;
    logic next_resynced;
    crf_tq_t prop_tq;
    crf_tq_t seg1_tq;
    crf_tq_t seg2_tq;
    crf_tq_t amt;
    crf_tq_t last_ext;
    crf_tq_t last_cut;
    crf_tq_t next_ext;
    crf_tq_t next_cut;
    logic [4:0] err;
    logic sample_c;
    logic start_c;

    assign prop_tq = {1'b0, PROP_LEN} + 4'h1;
    assign seg1_tq = {1'b0, SEG1_LEN} + 4'h1;
    assign seg2_tq = {1'b0, SEG2_LEN} + 4'h1;

    always_comb begin
        next_seg = seg;
        next_cnt = tq_cnt;
        next_ph1 = ph1_lim;
        next_ph2 = ph2_lim;
        next_resynced = resynced;
        next_ext = last_ext;
        next_cut = last_cut;
        err = 5'h00;
        amt = 4'h0;
        sample_c = 1'b0;
        start_c = 1'b0;
        if (HARD_SYNC) begin
            // restart the bit; no resync is allowed in this bit
            next_seg = CRF_SYNC;
            next_cnt = 4'h0;
            next_ph1 = seg1_tq;
            next_ph2 = seg2_tq;
            next_resynced = 1'b1;
        end else begin
            if (RX_EDGE && !resynced) begin
                unique case (seg)
                    CRF_SYNC: err = 5'h00;
                    CRF_PROP: err = {1'b0, tq_cnt} + 5'h01;
                    CRF_PH1: err = {1'b0, prop_tq} + {1'b0, tq_cnt} + 5'h01;
                    CRF_PH2: err = {1'b0, ph2_lim} - {1'b0, tq_cnt};
                endcase
                amt = (err > {1'b0, sjw_tq}) ? sjw_tq : err[3:0]; // R2
                next_resynced = 1'b1;
                if (seg == CRF_PROP || seg == CRF_PH1) begin
                    next_ph1 = ph1_lim + amt; // R1 R4
                    next_ext = amt;
                end else if (seg == CRF_PH2) begin
                    next_ph2 = ph2_lim - amt; // R1 R4
                    next_cut = amt;
                end
            end
            if (TQ_TICK) begin
                next_cnt = tq_cnt + 4'h1;
                unique case (seg)
                    CRF_SYNC: begin
                        next_seg = CRF_PROP;
                        next_cnt = 4'h0;
                    end
                    CRF_PROP: begin
                        if (next_cnt >= prop_tq) begin
                            next_seg = CRF_PH1;
                            next_cnt = 4'h0;
                        end
                    end
                    CRF_PH1: begin
                        if (next_cnt >= next_ph1) begin
                            next_seg = CRF_PH2;
                            next_cnt = 4'h0;
                            sample_c = 1'b1;
                        end
                    end
                    CRF_PH2: begin
                        // a cut that reaches the count ends the bit at this quantum
                        if (next_cnt >= next_ph2) begin
                            next_seg = CRF_SYNC;
                            next_cnt = 4'h0;
                            next_ph1 = seg1_tq;
                            next_ph2 = seg2_tq;
                            next_resynced = 1'b0;
                            start_c = 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            seg <= CRF_SYNC;
            tq_cnt <= 4'h0;
            ph1_lim <= 4'h1;
            ph2_lim <= 4'h1;
            resynced <= 1'b0;
        end else begin
            seg <= next_seg;
            tq_cnt <= next_cnt;
            ph1_lim <= next_ph1;
            ph2_lim <= next_ph2;
            resynced <= next_resynced;
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            last_ext <= 4'h0;
            last_cut <= 4'h0;
        end else begin
            last_ext <= next_ext;
            last_cut <= next_cut;
        end
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            SAMPLE_POINT <= 1'b0;
            BIT_START <= 1'b0;
            BIT_PHASE <= 2'b00;
        end else begin
            SAMPLE_POINT <= sample_c;
            BIT_START <= start_c;
            BIT_PHASE <= next_seg;
        end
    end

    // acceptance filters
    logic [15:0] f_sid [NUM_FILT];
    logic [15:0] f_eidh [NUM_FILT];
    logic [15:0] f_eidl [NUM_FILT];

    for (genvar k = 0; k < NUM_FILT; k++) begin : g_filt
        localparam logic [11:0] BASE = 12'(`CRF_F0_SID_IDX + k * FILT_STRIDE); // R10 R11

        crf_filter_regs u_filt (
            .clk(CLOCK),
            .rst_n(rst_n),
            .wr_sid(wr_strobe && pend_idx == BASE),
            .wr_eidh(wr_strobe && pend_idx == BASE + EIDH_OFS),
            .wr_eidl(wr_strobe && pend_idx == BASE + EIDL_OFS),
            .wdata(HWDATA[15:0]),
            .rx_id(RX_ID),
            .rx_ide(RX_IDE),
            .rx_valid(RX_ID_VALID),
            .rd_sid(f_sid[k]),
            .rd_eidh(f_eidh[k]),
            .rd_eidl(f_eidl[k]),
            .hit(FILTER_HIT[k])
        );
    end

    // unmapped addresses read zero and ignore writes
    always_comb begin
        rd_val = 16'h0000;
        if (pend_ok) begin
            if (pend_idx == `CRF_CFG1_IDX) begin
                rd_val = {8'h00, cfg1};
            end else if (pend_idx == `CRF_STAT_IDX) begin
                rd_val = {4'h0, last_cut, last_ext, 1'b0, resynced, seg};
            end
            for (int k = 0; k < NUM_FILT; k++) begin
                if (pend_idx == 12'(`CRF_F0_SID_IDX + k * FILT_STRIDE)) begin
                    rd_val = f_sid[k];
                end else if (pend_idx == 12'(`CRF_F0_SID_IDX + k * FILT_STRIDE) + EIDH_OFS) begin
                    rd_val = f_eidh[k];
                end else if (pend_idx == 12'(`CRF_F0_SID_IDX + k * FILT_STRIDE) + EIDL_OFS) begin
                    rd_val = f_eidl[k];
                end
            end
        end
    end

    sequence s_cfg_write;
        wr_strobe && pend_idx == `CRF_CFG1_IDX;
    endsequence

    sequence s_edge_ph1;
        RX_EDGE && !resynced && !HARD_SYNC && !TQ_TICK && seg == CRF_PH1;
    endsequence

    sequence s_edge_ph2;
        RX_EDGE && !resynced && !HARD_SYNC && !TQ_TICK && seg == CRF_PH2;
    endsequence

    sequence s_wait_then_ready;
        !HREADYOUT ##1 HREADYOUT;
    endsequence

    AST_SJW_FIELD: assert property (s_cfg_write |=> sjw_tq == {2'b00, $past(HWDATA[7:6])} + 4'h1) // R3 R12 R5
        else $error("jump width not taken from config bits 7:6");
    // a hard sync reloads the limits, which is not an adjustment
    AST_EXT_BOUND: assert property ((ph1_lim > $past(ph1_lim)) && !$past(start_c) // R2
        && !$past(HARD_SYNC) |-> ph1_lim - $past(ph1_lim) <= $past(sjw_tq))
        else $error("phase one stretched beyond jump width");
    AST_CUT_BOUND: assert property ((ph2_lim < $past(ph2_lim)) && !$past(start_c) // R2
        && !$past(HARD_SYNC) |-> $past(ph2_lim) - ph2_lim <= $past(sjw_tq))
        else $error("phase two shrunk beyond jump width");
    AST_LENGTHEN: assert property (s_edge_ph1 |=> ph1_lim > $past(ph1_lim) && resynced) // R1 R4
        else $error("late edge did not stretch phase one");
    AST_SHORTEN: assert property (s_edge_ph2 |=> ph2_lim < $past(ph2_lim) && resynced) // R1 R4
        else $error("early edge did not shrink phase two");
    AST_ONE_RESYNC: assert property (resynced && !start_c && !HARD_SYNC |=> ph1_lim == $past(ph1_lim) // R2
        && ph2_lim == $past(ph2_lim))
        else $error("second adjustment within one bit");
    AST_HARD_SYNC: assert property (HARD_SYNC |=> seg == CRF_SYNC && resynced && tq_cnt == 4'h0)
        else $error("hard sync did not restart the bit");
    AST_BUS_WAIT: assert property (accept |=> s_wait_then_ready)
        else $error("transfer did not take exactly one wait state");
    AST_EIDL_RSVD: assert property (accept && !HWRITE && HADDR[13:2] == `CRF_F0_EIDL_IDX // R9
        && HADDR[31:14] == 18'h00000 |-> ##2 HRDATA[9:0] == 10'h000 && HRDATA[31:16] == 16'h0000)
        else $error("low extended register reserved bits not zero");
endmodule : crf_resync_top
`default_nettype wire

// ### hw/crf_defs.svh
// register offsets, field positions and reset values for the resync and filter block
// What this block does
// (R1) Resync edge stretches phase one or shrinks two
// (R2) Adjustment never exceeds the jump width
// (R3) Jump width field sits in config bits 7:6
// (R4) Add width to phase one, subtract from two
// (R5) Jump width spans one to four quanta
// (R6) Software keeps phase two above jump width
// (R7) Standard register: 11-bit identifier, extended flag bit 0
// (R8) High register holds extended bits 17 to 6
// (R9) Low register upper bits hold bits 5:0
// (R10) Filter registers two indices apart, filter stride eight
// (R11) Later filters reuse the same three-register layout
// (R12) Field 00 means one quantum, 11 four
// (R13) Flag clear matches standard, set matches extended
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// register indices; byte address is four times the index
`define CRF_F0_SID_IDX 12'h300
`define CRF_F0_EIDH_IDX 12'h302
`define CRF_F0_EIDL_IDX 12'h304
`define CRF_F1_SID_IDX 12'h308
`define CRF_F1_EIDH_IDX 12'h30A
`define CRF_F1_EIDL_IDX 12'h30C
`define CRF_F2_SID_IDX 12'h310
`define CRF_F2_EIDH_IDX 12'h312
`define CRF_F2_EIDL_IDX 12'h314
`define CRF_CFG1_IDX 12'h2A0
`define CRF_STAT_IDX 12'h2A2

`define CRF_SJW_HI 7
`define CRF_SJW_LO 6
`define CRF_BRP_HI 5
`define CRF_SID_HI 12
`define CRF_SID_LO 2
`define CRF_EXT_BIT 0
`define CRF_EIDH_HI 11
`define CRF_EIDL_HI 15
`define CRF_EIDL_LO 10

`define CRF_CFG1_RST 8'h00
`define CRF_FILT_RST 16'h0000
`define CRF_HSIZE_WORD 3'h2

`endif

// ### hw/crf_pkg.sv
// types shared by the resync and filter block
`default_nettype none
package crf_pkg;
    typedef enum logic [1:0] {
        CRF_SYNC = 2'b00,
        CRF_PROP = 2'b01,
        CRF_PH1 = 2'b10,
        CRF_PH2 = 2'b11
    } crf_seg_t;
    typedef logic [3:0] crf_tq_t;
endpackage : crf_pkg
`default_nettype wire

// ### hw/crf_filter_regs.sv
// one acceptance filter: three identifier registers and an exact match
`include "crf_defs.svh"
`default_nettype none
module crf_filter_regs
    import crf_pkg::*;
#(
    parameter int SID_W = 11,
    parameter int EID_W = 18
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_sid,
    input wire logic wr_eidh,
    input wire logic wr_eidl,
    input wire logic [15:0] wdata,
    input wire logic [28:0] rx_id,
    input wire logic rx_ide,
    input wire logic rx_valid,
    output logic [15:0] rd_sid,
    output logic [15:0] rd_eidh,
    output logic [15:0] rd_eidl,
    output logic hit
);
    if (SID_W != 11 || EID_W != 18) begin : g_chk
        $error("identifier widths are fixed by the register layout");
    end

    logic [SID_W-1:0] sid;
    logic [EID_W-1:0] eid;
    logic ext_flag;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sid <= '0;
            ext_flag <= 1'b0;
        end else if (wr_sid) begin
            sid <= wdata[`CRF_SID_HI:`CRF_SID_LO]; // R7
            ext_flag <= wdata[`CRF_EXT_BIT]; // R7
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eid <= '0;
        end else begin
            if (wr_eidh) begin
                eid[17:6] <= wdata[`CRF_EIDH_HI:0]; // R8
            end
            if (wr_eidl) begin
                eid[5:0] <= wdata[`CRF_EIDL_HI:`CRF_EIDL_LO]; // R9
            end
        end
    end

    // unimplemented bits read as zero
    assign rd_sid = {3'h0, sid, 1'b0, ext_flag};
    assign rd_eidh = {4'h0, eid[17:6]};
    assign rd_eidl = {eid[5:0], 10'h000};

    // no acceptance mask is applied; here the compare is exact
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hit <= 1'b0;
        end else begin
            hit <= rx_valid && (rx_ide == ext_flag) && (rx_id[28:18] == sid) // R13
                && (!ext_flag || rx_id[17:0] == eid);
        end
    end

    AST_STD_LAYOUT: assert property (@(posedge clk) disable iff (!rst_n) // R7
        wr_sid |=> rd_sid == ($past(wdata) & 16'h1FFD))
        else $error("standard id register layout wrong");
    AST_EIDH_LAYOUT: assert property (@(posedge clk) disable iff (!rst_n) // R8
        wr_eidh |=> rd_eidh == {4'h0, $past(wdata[11:0])})
        else $error("extended high register layout wrong");
    AST_FORMAT_ONLY: assert property (@(posedge clk) disable iff (!rst_n) // R13
        hit |-> ($past(rx_ide) == $past(ext_flag)) && $past(rx_valid))
        else $error("filter matched a frame of the wrong format");
endmodule : crf_filter_regs
`default_nettype wire

// ### testbench/crf_node_model.sv
// far-side stand-in: quantum tick, bus edges and received identifiers from other nodes
`default_nettype none
module crf_node_model (
    input wire logic clk,
    input wire logic edge_req,
    output logic tick,
    output logic rx_edge,
    output logic [28:0] rx_id,
    output logic rx_ide,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div = 2'h0;
    initial begin
        rx_id = 29'h0;
        rx_ide = 1'b0;
        rx_valid = 1'b0;
    end
    // one quantum every four clocks, leaves room to place edges inside a segment
    always @(posedge clk) begin
        div <= div + 2'h1;
        tick <= (div == 2'h3);
    end
    always @(posedge clk) begin
        rx_edge <= edge_req;
    end
    task send_id(input logic [28:0] id, input logic ide);
        @(posedge clk);
        rx_id <= id;
        rx_ide <= ide;
        rx_valid <= 1'b1;
        @(posedge clk);
        rx_valid <= 1'b0;
        // stale identifier is not left standing after the strobe
        rx_id <= ~id;
        rx_ide <= ~ide;
    endtask : send_id
endmodule : crf_node_model
`default_nettype wire

// ### testbench/can_resync_and_filter_regs_tb.sv
// self-checking bench: register bus, filter registers and matches, resync bit lengths
`include "crf_defs.svh"
`default_nettype none
module can_resync_and_filter_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    localparam logic [31:0] ADR [10] = '{32'hC00, 32'hC08, 32'hC10, 32'hC20, 32'hC28, 32'hC30,
        32'hC40, 32'hC48, 32'hC50, 32'hC18};
    localparam logic [31:0] WDT [10] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h5555, 32'hAAAA,
        32'h5555, 32'h2AAA, 32'h0123, 32'hA800, 32'hFFFF};
    localparam logic [31:0] EXP [10] = '{32'h1FFD, 32'h0FFF, 32'hFC00, 32'h1555, 32'h0AAA, 32'h5400,
        32'h0AA8, 32'h0123, 32'hA800, 32'h0};
    localparam logic [28:0] FID [5] = '{{11'h5A3, 18'h0}, {11'h5A3, 18'h0}, {11'h555, 18'h2AA95},
        {11'h555, 18'h2AA94}, {11'h2AA, 18'h3FFFF}};
    localparam logic FIDE [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    localparam logic [2:0] FEXP [5] = '{3'b001, 3'b000, 3'b010, 3'b000, 3'b100};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic edge_req = 1'b0;
    logic hard_sync = 1'b0;
    wire logic sample_point;
    wire logic [1:0] bit_phase;
    int sp;
    wire logic hready_out, hresp, tick, rx_edge, rx_ide, rx_valid, bit_start;
    wire logic [31:0] hrdata;
    wire logic [28:0] rx_id;
    wire logic [5:0] prescale;
    wire logic [2:0] hit;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    logic [31:0] rd;

    crf_node_model node (.clk(clock), .edge_req(edge_req), .tick(tick), .rx_edge(rx_edge), .rx_id(rx_id),
        .rx_ide(rx_ide), .rx_valid(rx_valid));
    crf_resync_top #(.NUM_FILT(3)) dut (.CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(`CRF_HSIZE_WORD), .HWDATA(hwdata), .HREADY(hready_out),
        .HRDATA(hrdata), .HREADYOUT(hready_out), .HRESP(hresp), .TQ_TICK(tick), .PROP_LEN(3'h0),
        .SEG1_LEN(3'h7), .SEG2_LEN(3'h7), .RX_EDGE(rx_edge), .HARD_SYNC(hard_sync), .RX_ID(rx_id),
        .RX_IDE(rx_ide), .RX_ID_VALID(rx_valid), .PRESCALE(prescale), .BIT_PHASE(bit_phase),
        .SAMPLE_POINT(sample_point),
        .BIT_START(bit_start), .FILTER_HIT(hit));

    initial begin
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count = bad_count + 1;
            conclude();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task conclude();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude
    task do_reset();
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask : do_reset
    task xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clock);
        while (hready_out !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge clock);
        while (hready_out !== 1'b1) @(posedge clock);
        r = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask : xfer
    // counts quanta of one whole bit; edges placed at quantum counts, -1 for none
    task run_bit(input int at, input logic dbl, output int cnt, output int sp);
        int fired;
        cnt = 0;
        sp = -1;
        fired = -1;
        @(posedge clock);
        while (bit_start !== 1'b1) @(posedge clock);
        @(posedge clock);
        while (bit_start !== 1'b1) begin
            if (tick === 1'b1) cnt++;
            if (sample_point === 1'b1) begin
                sp = cnt;
                check({30'h0, bit_phase}, 32'h3);
            end
            if ((cnt == at || (dbl && cnt == at + 1)) && cnt != fired) begin
                edge_req <= 1'b1;
                fired = cnt;
            end else edge_req <= 1'b0;
            @(posedge clock);
        end
        edge_req <= 1'b0;
    endtask : run_bit

    initial begin
        do_reset();
        for (int i = 0; i < 10; i++) begin
            xfer(ADR[i], 1'b1, WDT[i], rd);
            xfer(ADR[i], 1'b0, 32'h0, rd);
            check(rd, EXP[i]);
        end
        xfer(32'hC00, 1'b1, 32'h168C, rd);
        for (int i = 0; i < 5; i++) begin
            node.send_id(FID[i], FIDE[i]);
            #1;
            check({29'h0, hit}, {29'h0, FEXP[i]});
        end
        // nominal bit is sync + prop + phase one + phase two quanta
        run_bit(-1, 1'b0, n, sp);
        check(32'(n), 32'd18);
        check(32'(sp), 32'd10);
        for (int s = 0; s < 4; s++) begin
            xfer(32'hA80, 1'b1, {24'h0, s[1:0], 6'h15}, rd);
            xfer(32'hA80, 1'b0, 32'h0, rd);
            check(rd, {24'h0, s[1:0], 6'h15});
            check({26'h0, prescale}, 32'h15);
            // late edge in phase one, repeated: only the first may stretch
            run_bit(7, 1'b1, n, sp);
            check(32'(n), 32'(19 + s));
            check(32'(sp), 32'(11 + s));
            xfer(32'hA88, 1'b0, 32'h0, rd);
            check((rd >> 4) & 32'hF, 32'(s + 1));
            run_bit(11, 1'b0, n, sp);
            check(32'(n), 32'(17 - s));
            check(32'(sp), 32'd10);
        end
        // widest field clamps the last cut of seven quanta to four
        xfer(32'hA88, 1'b0, 32'h0, rd);
        check((rd >> 8) & 32'hF, 32'h4);
        // hard sync restarts the bit and spends its one adjustment
        @(posedge clock);
        hard_sync <= 1'b1;
        @(posedge clock);
        hard_sync <= 1'b0;
        @(posedge clock);
        check({30'h0, bit_phase}, 32'h0);
        xfer(32'hA88, 1'b0, 32'h0, rd);
        check((rd >> 2) & 32'h1, 32'h1);
        do_reset();
        for (int i = 0; i < 10; i++) begin
            xfer(ADR[i], 1'b0, 32'h0, rd);
            check(rd, 32'h0);
        end
        check({26'h0, prescale}, 32'h0);
        conclude();
    end
endmodule : can_resync_and_filter_regs_tb
`default_nettype wire
